// ---- core/bvp_regs.sv ----
// Parameter and control register bank of the 2D drawing pipeline
// What this block does
// - Writing the block-transfer mode register while idle starts a block transfer with current parameters.
// - Status register holds configuration and status; status bits sit in low byte.
// - Legacy video base register holds emulated memory offset from graphics memory start.
// - Legacy latch register gives read and write access to the display latch.
// - Block transfer: destination bits 31..16 are signed destination Y.
// - Block transfer: destination bits 15..0 are signed destination X.
// - Line: destination upper half is signed start Y.
// - Line: destination lower half is signed start X.
// - Block transfer: size bits 31..16 are unsigned width; zero width draws nothing.
// - Line: size bits 31..30 reserved, 14-bit length; zero length draws nothing.
// - Block transfer: size bits 15..0 are unsigned height; zero height draws nothing.
// - Line: size lower half is the initial error term.
// - Block transfer: source bits 31..16 are signed source X.
// - Line: source upper half is signed axial error increment.
// - Block transfer: source bits 15..0 are signed source Y.
// - Line: source lower half is signed diagonal error increment.
// - Writing the line mode register while idle starts a line with current parameters.
`timescale 1ns/100ps
module bvp_regs (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic reg_sel,
   input wire logic reg_wr,
   input wire logic [15:0] reg_addr,
   input wire logic [3:0] reg_be,
   input wire logic [31:0] reg_wdata,
   output logic [31:0] reg_rdata,
   output logic reg_rvalid,
   output logic engine_start,
   output logic engine_is_line,
   output bvp_pkg::bvp_blit_s engine_blit,
   output bvp_pkg::bvp_line_s engine_line,
   output logic [31:0] engine_mode,
   input wire logic engine_done,
   output logic [31:0] legacy_video_base,
   output logic [31:0] legacy_latch,
   input wire logic latch_load,
   input wire logic [31:0] latch_load_data
);

   // ****************************************
   // Registers
   // ****************************************
   logic [31:0] dest_coord_reg;
   logic [31:0] size_reg;
   logic [31:0] source_coord_reg;
   logic [31:0] line_mode_reg;
   logic [31:0] blit_mode_reg;
   logic [31:0] blit_status_reg;
   logic [31:0] legacy_video_base_reg;
   logic [31:0] legacy_latch_reg;
   bvp_pkg::bvp_state_e state_reg;
   bvp_pkg::bvp_state_e state_next;
   logic is_line_reg;
   logic empty_reg;
   bvp_pkg::bvp_blit_s op_blit_reg;
   bvp_pkg::bvp_line_s op_line_reg;
   logic [31:0] op_mode_reg;
   logic [31:0] rdata_reg;
   logic rvalid_reg;

   // ****************************************
   // Address decode
   // ****************************************
   wire wr_en = reg_sel && reg_wr;
   wire rd_en = reg_sel && !reg_wr;
   wire hit_dest = (reg_addr == bvp_pkg::OFF_DEST);
   wire hit_size = (reg_addr == bvp_pkg::OFF_SIZE);
   wire hit_src = (reg_addr == bvp_pkg::OFF_SRC);
   wire hit_lmode = (reg_addr == bvp_pkg::OFF_LINE_MODE);
   wire hit_bmode = (reg_addr == bvp_pkg::OFF_BLIT_MODE);
   wire hit_stat = (reg_addr == bvp_pkg::OFF_STATUS);
   wire hit_base = (reg_addr == bvp_pkg::OFF_LEG_BASE);
   wire hit_latch = (reg_addr == bvp_pkg::OFF_LEG_LATCH);
   wire [31:0] be_mask = {{8{reg_be[3]}}, {8{reg_be[2]}}, {8{reg_be[1]}}, {8{reg_be[0]}}};
   wire busy = (state_reg != bvp_pkg::BVP_ST_IDLE);

   // ****************************************
   // Start requests, taken only while idle
   // ****************************************
   wire start_blit = wr_en && hit_bmode && !busy;
   wire start_line = wr_en && hit_lmode && !busy;
   wire start_any = start_blit || start_line;

   // Byte-lane merge of write data into an old value
   function automatic logic [31:0] merge(input logic [31:0] old_val,
                                         input logic [31:0] new_val,
                                         input logic [31:0] mask);
      merge = (old_val & ~mask) | (new_val & mask);
   endfunction

   // ****************************************
   // Mode-specific views of the parameters
   // ****************************************
   bvp_pkg::bvp_blit_s blit_view;
   bvp_pkg::bvp_line_s line_view;
   logic blit_empty;
   logic line_empty;

   bvp_param_decode u_decode (
      .dest_coord(dest_coord_reg),
      .size_word(size_reg),
      .source_coord(source_coord_reg),
      .blit(blit_view),
      .line(line_view),
      .blit_empty(blit_empty),
      .line_empty(line_empty)
   );

   // Empty operation finishes at once without engine activity
   wire op_empty = start_line ? line_empty : blit_empty;
   // Only a start with something to draw reaches the engine
   wire start_real = start_any && !op_empty;

   // ****************************************
   // Parameter registers, software written only
   // ****************************************
   always_ff @(posedge core_clk) begin
      if (reset) begin
         dest_coord_reg <= bvp_pkg::RST_PARAM;
         size_reg <= bvp_pkg::RST_PARAM;
         source_coord_reg <= bvp_pkg::RST_PARAM;
      end else if (wr_en) begin
         // Completion never touches these
         if (hit_dest) dest_coord_reg <= merge(dest_coord_reg, reg_wdata, be_mask);
         if (hit_size) size_reg <= merge(size_reg, reg_wdata, be_mask);
         if (hit_src) source_coord_reg <= merge(source_coord_reg, reg_wdata, be_mask);
      end
   end

   // ****************************************
   // Mode registers
   // ****************************************
   always_ff @(posedge core_clk) begin
      if (reset) begin
         line_mode_reg <= bvp_pkg::RST_MODE;
         blit_mode_reg <= bvp_pkg::RST_MODE;
      end else begin
         if (start_line) line_mode_reg <= merge(line_mode_reg, reg_wdata, be_mask);
         if (start_blit) blit_mode_reg <= merge(blit_mode_reg, reg_wdata, be_mask);
      end
   end

   // ****************************************
   // Status: configuration above, status in low byte
   // ****************************************
   always_ff @(posedge core_clk) begin
      if (reset) begin
         blit_status_reg <= bvp_pkg::RST_STATUS_CFG;
      end else if (wr_en && hit_stat) begin
         blit_status_reg <= merge(blit_status_reg, reg_wdata, be_mask);
      end
   end

   // ****************************************
   // Legacy video emulation registers
   // ****************************************
   // Emulated memory offset, software written only
   always_ff @(posedge core_clk) begin
      if (reset) begin
         legacy_video_base_reg <= bvp_pkg::RST_LEGACY;
      end else if (wr_en && hit_base) begin
         legacy_video_base_reg <= merge(legacy_video_base_reg, reg_wdata, be_mask);
      end
   end

   // Display latch, software write wins over a hardware latch load
   always_ff @(posedge core_clk) begin
      if (reset) begin
         legacy_latch_reg <= bvp_pkg::RST_LEGACY;
      end else if (wr_en && hit_latch) begin
         legacy_latch_reg <= merge(legacy_latch_reg, reg_wdata, be_mask);
      end else if (latch_load) begin
         legacy_latch_reg <= latch_load_data;
      end
   end

   // ****************************************
   // Operation sequencer
   // ****************************************
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         bvp_pkg::BVP_ST_IDLE: begin
            if (start_any && !op_empty) state_next = bvp_pkg::BVP_ST_ISSUE;
         end
         bvp_pkg::BVP_ST_ISSUE: begin
            state_next = bvp_pkg::BVP_ST_WAIT;
         end
         bvp_pkg::BVP_ST_WAIT: begin
            if (engine_done) state_next = bvp_pkg::BVP_ST_IDLE;
         end
         default: begin
            state_next = bvp_pkg::BVP_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         state_reg <= bvp_pkg::BVP_ST_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // ****************************************
   // Snapshot of the programmed parameters at the start write
   // ****************************************
   // Kind and extent of the last start write, empty ones too
   always_ff @(posedge core_clk) begin
      if (reset) begin
         is_line_reg <= 1'b0;
         empty_reg <= 1'b0;
      end else if (start_any) begin
         is_line_reg <= start_line;
         empty_reg <= op_empty;
      end
   end

   // Engine parameters, kept steady until the next real start
   always_ff @(posedge core_clk) begin
      if (reset) begin
         op_blit_reg <= '0;
         op_line_reg <= '0;
         op_mode_reg <= bvp_pkg::RST_MODE;
      end else if (start_real) begin
         op_blit_reg <= blit_view;
         op_line_reg <= line_view;
         op_mode_reg <= merge(start_line ? line_mode_reg : blit_mode_reg, reg_wdata, be_mask);
      end
   end

   // ****************************************
   // Read path, one cycle latency
   // ****************************************
   logic [7:0] status_byte;

   // Status flags at their named positions, unused bits zero
   always_comb begin
      status_byte = 8'h00;
      status_byte[bvp_pkg::STAT_BUSY] = busy;
      status_byte[bvp_pkg::STAT_LINE] = is_line_reg;
      status_byte[bvp_pkg::STAT_EMPTY] = empty_reg;
   end

   wire [31:0] status_word = {blit_status_reg[31:bvp_pkg::STAT_CFG_LSB], status_byte};
   logic [31:0] rd_mux;

   always_comb begin
      if (hit_dest) rd_mux = dest_coord_reg;
      else if (hit_size) rd_mux = size_reg;
      else if (hit_src) rd_mux = source_coord_reg;
      else if (hit_lmode) rd_mux = line_mode_reg;
      else if (hit_bmode) rd_mux = blit_mode_reg;
      else if (hit_stat) rd_mux = status_word;
      else if (hit_base) rd_mux = legacy_video_base_reg;
      else if (hit_latch) rd_mux = legacy_latch_reg;
      else rd_mux = 32'h0000_0000;
   end

   // Answer strobe, one cycle after each read request
   always_ff @(posedge core_clk) begin
      if (reset) begin
         rvalid_reg <= 1'b0;
      end else begin
         rvalid_reg <= rd_en;
      end
   end

   // Read data, held until the next read
   always_ff @(posedge core_clk) begin
      if (reset) begin
         rdata_reg <= 32'h0000_0000;
      end else if (rd_en) begin
         rdata_reg <= rd_mux;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   // Register bus answer
   assign reg_rdata = rdata_reg;
   assign reg_rvalid = rvalid_reg;

   // Engine handshake and parameter snapshot
   assign engine_start = (state_reg == bvp_pkg::BVP_ST_ISSUE);
   assign engine_is_line = is_line_reg;
   assign engine_blit = op_blit_reg;
   assign engine_line = op_line_reg;
   assign engine_mode = op_mode_reg;

   // Legacy video emulation values
   assign legacy_video_base = legacy_video_base_reg;
   assign legacy_latch = legacy_latch_reg;

endmodule

// ---- include/bvp_pkg.sv ----
// Package: offsets, reset values, field positions and carrier types of the parameter bank
package bvp_pkg;

   // ****************************************
   // Register offsets (byte addresses)
   // ****************************************
   localparam logic [15:0] OFF_DEST = 16'h8100;
   localparam logic [15:0] OFF_SIZE = 16'h8104;
   localparam logic [15:0] OFF_SRC = 16'h8108;
   localparam logic [15:0] OFF_LINE_MODE = 16'h8204;
   localparam logic [15:0] OFF_BLIT_MODE = 16'h8208;
   localparam logic [15:0] OFF_STATUS = 16'h820C;
   localparam logic [15:0] OFF_LEG_BASE = 16'h8210;
   localparam logic [15:0] OFF_LEG_LATCH = 16'h8214;

   // ****************************************
   // Reset values
   // ****************************************
   localparam logic [31:0] RST_PARAM = 32'h0000_0000;
   localparam logic [31:0] RST_MODE = 32'h0000_0000;
   localparam logic [31:0] RST_STATUS_CFG = 32'h0000_0000;
   localparam logic [31:0] RST_LEGACY = 32'h0000_0000;

   // ****************************************
   // Field positions
   // ****************************************
   localparam int HI_MSB = 31;
   localparam int HI_LSB = 16;
   localparam int LO_MSB = 15;
   localparam int LO_LSB = 0;
   localparam int LEN_MSB = 29;
   localparam int STAT_BUSY = 0;
   localparam int STAT_LINE = 1;
   localparam int STAT_EMPTY = 2;
   localparam int STAT_CFG_LSB = 8;

   // ****************************************
   // Types
   // ****************************************
   typedef enum logic [1:0] {
      BVP_ST_IDLE = 2'b00,
      BVP_ST_ISSUE = 2'b01,
      BVP_ST_WAIT = 2'b11
   } bvp_state_e;

   typedef struct packed {
      logic signed [15:0] dest_y;
      logic signed [15:0] dest_x;
      logic [15:0] width;
      logic [15:0] height;
      logic signed [15:0] source_x;
      logic signed [15:0] source_y;
   } bvp_blit_s;

   typedef struct packed {
      logic signed [15:0] start_y;
      logic signed [15:0] start_x;
      logic [13:0] length;
      logic [15:0] init_err;
      logic signed [15:0] axial_err;
      logic signed [15:0] line_diagonal_err;
   } bvp_line_s;

endpackage

// ---- core/bvp_param_decode.sv ----
// Decodes the three shared parameter words into block-transfer and line views
`timescale 1ns/100ps
module bvp_param_decode (
   input wire logic [31:0] dest_coord,
   input wire logic [31:0] size_word,
   input wire logic [31:0] source_coord,
   output bvp_pkg::bvp_blit_s blit,
   output bvp_pkg::bvp_line_s line,
   output logic blit_empty,
   output logic line_empty
);

   // ****************************************
   // Block-transfer view
   // ****************************************
   assign blit.dest_y = dest_coord[bvp_pkg::HI_MSB:bvp_pkg::HI_LSB];
   assign blit.dest_x = dest_coord[bvp_pkg::LO_MSB:bvp_pkg::LO_LSB];
   assign blit.width = size_word[bvp_pkg::HI_MSB:bvp_pkg::HI_LSB];
   assign blit.height = size_word[bvp_pkg::LO_MSB:bvp_pkg::LO_LSB];
   assign blit.source_x = source_coord[bvp_pkg::HI_MSB:bvp_pkg::HI_LSB];
   assign blit.source_y = source_coord[bvp_pkg::LO_MSB:bvp_pkg::LO_LSB];

   // ****************************************
   // Line view, top two length bits ignored
   // ****************************************
   assign line.start_y = dest_coord[bvp_pkg::HI_MSB:bvp_pkg::HI_LSB];
   assign line.start_x = dest_coord[bvp_pkg::LO_MSB:bvp_pkg::LO_LSB];
   assign line.length = size_word[bvp_pkg::LEN_MSB:bvp_pkg::HI_LSB];
   assign line.init_err = size_word[bvp_pkg::LO_MSB:bvp_pkg::LO_LSB];
   assign line.axial_err = source_coord[bvp_pkg::HI_MSB:bvp_pkg::HI_LSB];
   assign line.line_diagonal_err = source_coord[bvp_pkg::LO_MSB:bvp_pkg::LO_LSB];

   // Zero extent means nothing to draw
   assign blit_empty = (blit.width == 16'h0000) || (blit.height == 16'h0000);
   assign line_empty = (line.length == 14'h0000);

endmodule

// ---- bench/bvp_regs_assertions.sv ----
// Port-level assertions for the parameter register bank
`timescale 1ns/100ps
module bvp_regs_checker (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic reg_sel,
   input wire logic reg_wr,
   input wire logic [15:0] reg_addr,
   input wire logic [3:0] reg_be,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_rvalid,
   input wire logic engine_start,
   input wire logic engine_is_line,
   input wire bvp_pkg::bvp_blit_s engine_blit,
   input wire bvp_pkg::bvp_line_s engine_line,
   input wire logic [31:0] legacy_video_base,
   input wire logic [31:0] legacy_latch,
   input wire logic latch_load,
   input wire logic [31:0] latch_load_data
);
   // ****************
   // Checks
   // ****************
   default clocking @(posedge core_clk); endclocking
   default disable iff (reset);
   // Request decode of the register bus
   wire rd_req = reg_sel && !reg_wr;
   wire wr_req = reg_sel && reg_wr;
   wire line_addr = (reg_addr == 16'h8204);
   wire mode_wr = wr_req && (line_addr || reg_addr == 16'h8208);
   wire latch_wr = wr_req && (reg_addr == 16'h8214);
   wire full_be = (reg_be == 4'hF);
   wire base_wr = wr_req && (reg_addr == 16'h8210) && full_be;
   sequence s_rd;
      rd_req;
   endsequence
   sequence s_mode_wr;
      mode_wr;
   endsequence
   AST_READ_ANSWER: assert property (s_rd |=> reg_rvalid)
      else $error("read not answered next cycle");
   AST_ANSWER_CAUSE: assert property (reg_rvalid |-> $past(rd_req))
      else $error("read answer without read");
   AST_START_CAUSE: assert property (engine_start |-> $past(mode_wr))
      else $error("start without mode write");
   AST_START_PULSE: assert property (s_mode_wr ##1 engine_start |=> !engine_start)
      else $error("start longer than one cycle");
   AST_KIND: assert property (engine_start |-> engine_is_line == $past(line_addr))
      else $error("operation kind wrong");
   AST_BLIT_EXTENT: assert property (engine_start && !engine_is_line |->
         engine_blit.width != 16'h0000 && engine_blit.height != 16'h0000)
      else $error("empty block transfer started");
   AST_LINE_EXTENT: assert property (engine_start && engine_is_line |->
         engine_line.length != 14'h0000)
      else $error("empty line started");
   AST_SNAP_HOLD: assert property (!engine_start |->
         $stable(engine_blit) && $stable(engine_line))
      else $error("parameters changed without start");
   AST_LATCH_LOAD: assert property (latch_load && !latch_wr |->
         ##1 legacy_latch == $past(latch_load_data))
      else $error("latch load lost");
   AST_LATCH_WRITE: assert property (latch_wr && full_be |->
         ##1 legacy_latch == $past(reg_wdata))
      else $error("latch write lost");
   AST_BASE_WRITE: assert property (base_wr |->
         ##1 legacy_video_base == $past(reg_wdata))
      else $error("base write lost");
endmodule
bind bvp_regs bvp_regs_checker i_chk (.core_clk(core_clk), .reset(reset), .reg_sel(reg_sel),
   .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_be(reg_be), .reg_wdata(reg_wdata),
   .reg_rvalid(reg_rvalid), .engine_start(engine_start), .engine_is_line(engine_is_line),
   .engine_blit(engine_blit), .engine_line(engine_line), .legacy_video_base(legacy_video_base),
   .legacy_latch(legacy_latch), .latch_load(latch_load), .latch_load_data(latch_load_data));

// ---- bench/test_blit_vector_param_regs.sv ----
// Directed testbench for the parameter register bank
`timescale 1ns/100ps
module test_blit_vector_param_regs;
   logic core_clk, reset, reg_sel, reg_wr, reg_rvalid, engine_start, engine_is_line;
   logic engine_done, latch_load;
   logic [15:0] reg_addr;
   logic [3:0] reg_be;
   logic [31:0] reg_wdata, reg_rdata, engine_mode, legacy_video_base, legacy_latch;
   logic [31:0] latch_load_data;
   bvp_pkg::bvp_blit_s engine_blit;
   bvp_pkg::bvp_line_s engine_line;
   int fail_count = 0;
   int n_checks = 0;
   logic [15:0] offs [8] = '{16'h8100, 16'h8104, 16'h8108, 16'h8204, 16'h8208, 16'h820C,
      16'h8210, 16'h8214};
   bvp_regs i_dut (.core_clk(core_clk), .reset(reset), .reg_sel(reg_sel), .reg_wr(reg_wr),
      .reg_addr(reg_addr), .reg_be(reg_be), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid), .engine_start(engine_start), .engine_is_line(engine_is_line),
      .engine_blit(engine_blit), .engine_line(engine_line), .engine_mode(engine_mode),
      .engine_done(engine_done), .legacy_video_base(legacy_video_base),
      .legacy_latch(legacy_latch), .latch_load(latch_load), .latch_load_data(latch_load_data));
   // ****************
   // Clock and tasks
   // ****************
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   task automatic chk(input string nm, input logic [95:0] seen, input logic [95:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [3:0] be = 4'hF);
      @(posedge core_clk) #1;
      reg_sel = 1'b1;
      reg_wr = 1'b1;
      reg_addr = a;
      reg_be = be;
      reg_wdata = d;
      @(posedge core_clk) #1;
      reg_sel = 1'b0;
   endtask
   task automatic rd(input logic [15:0] a, input logic [31:0] exp);
      @(posedge core_clk) #1;
      reg_sel = 1'b1;
      reg_wr = 1'b0;
      reg_addr = a;
      @(posedge core_clk) #1;
      reg_sel = 1'b0;
      chk("rvalid", reg_rvalid, 1'b1);
      chk($sformatf("reg %h", a), reg_rdata, exp);
   endtask
   task automatic done_pulse;
      @(posedge core_clk) #1;
      engine_done = 1'b1;
      @(posedge core_clk) #1;
      engine_done = 1'b0;
   endtask
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   initial begin
      #200000;
      fail_count++;
      print_verdict();
   end
   // ****************
   // Main sequence
   // ****************
   initial begin
      reset = 1'b1;
      {reg_sel, reg_wr, engine_done, latch_load} = 4'h0;
      reg_addr = 16'h0;
      reg_be = 4'h0;
      reg_wdata = 32'h0;
      latch_load_data = 32'h0;
      repeat (12) @(posedge core_clk);
      #1 reset = 1'b0;
      for (int i = 0; i < 8; i++) rd(offs[i], 32'h0);
      wr(16'h8118, 32'hFFFF_FFFF);
      rd(16'h8118, 32'h0);
      wr(16'h8100, 32'hFFF6_0014);
      wr(16'h8100, 32'h0000_5500, 4'h2);
      rd(16'h8100, 32'hFFF6_5514);
      wr(16'h8104, 32'h0003_0005);
      wr(16'h8108, 32'h8001_7FFF);
      wr(16'h8208, 32'h0000_00A5);
      chk("start", engine_start, 1'b1);
      chk("kind", engine_is_line, 1'b0);
      chk("blit", engine_blit, 96'hFFF6_5514_0003_0005_8001_7FFF);
      chk("mode", engine_mode, 32'hA5);
      rd(16'h820C, 32'h1);
      wr(16'h8208, 32'h77);
      chk("start", engine_start, 1'b0);
      rd(16'h8208, 32'hA5);
      done_pulse();
      rd(16'h820C, 32'h0);
      rd(16'h8104, 32'h0003_0005);
      wr(16'h8104, 32'hC005_1234);
      wr(16'h8204, 32'h3);
      chk("start", engine_start, 1'b1);
      chk("kind", engine_is_line, 1'b1);
      chk("line start", engine_line[93:62], 32'hFFF6_5514);
      chk("line len", engine_line[61:32], {14'h5, 16'h1234});
      chk("line steps", engine_line[31:0], 32'h8001_7FFF);
      chk("mode", engine_mode, 32'h3);
      rd(16'h8204, 32'h3);
      done_pulse();
      rd(16'h820C, 32'h2);
      wr(16'h8104, 32'h0000_0005);
      wr(16'h8208, 32'h1);
      chk("start", engine_start, 1'b0);
      rd(16'h820C, 32'h4);
      wr(16'h8104, 32'h0007_0000);
      wr(16'h8208, 32'h1);
      chk("start", engine_start, 1'b0);
      wr(16'h8104, 32'hC000_0007);
      wr(16'h8204, 32'h1);
      chk("start", engine_start, 1'b0);
      wr(16'h820C, 32'hABCD_12FF);
      rd(16'h820C, 32'hABCD_1206);
      wr(16'h8210, 32'h0012_3400);
      rd(16'h8210, 32'h0012_3400);
      chk("base", legacy_video_base, 32'h0012_3400);
      wr(16'h8214, 32'h5A5A_A5A5);
      rd(16'h8214, 32'h5A5A_A5A5);
      @(posedge core_clk) #1;
      latch_load = 1'b1;
      latch_load_data = 32'h1357_9BDF;
      @(posedge core_clk) #1;
      latch_load = 1'b0;
      rd(16'h8214, 32'h1357_9BDF);
      chk("latch", legacy_latch, 32'h1357_9BDF);
      latch_load = 1'b1;
      wr(16'h8214, 32'h2468_ACE0);
      latch_load = 1'b0;
      chk("latch", legacy_latch, 32'h2468_ACE0);
      rd(16'h8214, 32'h2468_ACE0);
      print_verdict();
   end
endmodule
